/* File: src/tvs_pkg.sv */
// Package of constants and carrier types for the interlaced sync divider
package tvs_pkg;
    // Variant one: line divider and field divider
    localparam int unsigned H_DIV = 2;
    localparam logic [9:0] FIELD_LAST = 10'h20c;
    // Cascaded divider moduli, product 525
    localparam logic [1:0] MOD3_LAST = 2'h2;
    localparam logic [2:0] MOD5_LAST = 3'h4;
    localparam logic [2:0] MOD7_LAST = 3'h6;
    // Variant two: alternating 262/263 divider
    localparam logic [8:0] SKIP_POINT = 9'h100;
    localparam logic [3:0] UPPER_JUMP0 = 4'ha;
    localparam logic [3:0] UPPER_JUMP1 = 4'hb;
    localparam logic [3:0] UPPER_LAST = 4'hf;
    localparam logic [8:0] JUMP_COUNT0 = 9'h140;
    localparam logic [8:0] JUMP_COUNT1 = 9'h160;
    localparam int unsigned TOP_BIT = 8;
    localparam int unsigned LOW_BITS = 5;
    // Timing of the programmable stages
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned INTERLACE_DELAY_US = 50;
    localparam int unsigned DELAY_MAX_CYCLES = INTERLACE_DELAY_US * CLK_MHZ;
    localparam int unsigned DELAY_W = 13;
    localparam int unsigned WIDTH_W = 16;
    localparam logic [WIDTH_W-1:0] WIDTH_MIN = 16'h0001;
    // Reset values
    localparam logic [9:0] FIELD_RESET = 10'h000;
    localparam logic [8:0] ALT_RESET = 9'h000;

    // One line pulse and one field pulse travel together
    typedef struct packed {
        logic hSync;
        logic vSync;
    } tvs_sync_type;

    // One-hot state of a timed pulse stage
    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b01,
        PULSE_BUSY = 2'b10
    } tvs_pulse_state_type;
endpackage : tvs_pkg

/* File: src/tvs_sync_divider.sv */
// Sync divider for 525-line interlaced scan: fixed and adjustable interlace variants
//
// Summary of operation
// - Line pulse every two 31.5 kHz master periods
// - Field pulse every 525 master periods
// - Ten-bit counter runs 0 to 524
// - At 524, next master period returns to zero
// - Forbidden field counts fall back to zero
// - Cascaded 3, 5, 5, 7 dividers also give 525
// - Spare cascade stage supplies the line halving
// - 15.75 kHz tick fires line pulse, clocks divider
// - Divider alternates 262 and 263 period cycles
// - Count 0 to 256, then jump by select
// - Top stage set holds low five stages
// - Skip stage follows select flop during jump
// - Upper four count to overflow, then normal
// - Low stages forced clear while top is set
// - Field pulse low on select fall, high for the delay after select rise
// - Field pulse fall starts vertical sync width
`timescale 1ns/1ns
module tvs_sync_divider #(
    parameter int unsigned DELAY_MAX = tvs_pkg::DELAY_MAX_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic master31,
    input wire logic master15,
    input wire logic [tvs_pkg::DELAY_W-1:0] interlaceDelay,
    input wire logic [tvs_pkg::WIDTH_W-1:0] verticalPulseWidth,
    output tvs_pkg::tvs_sync_type fixedSync,
    output tvs_pkg::tvs_sync_type cascadeSync,
    output tvs_pkg::tvs_sync_type adjustSync,
    output logic fieldPulse,
    output logic interlaceSel
);
    import tvs_pkg::*;

    logic m31Prev_reg;
    logic m15Prev_reg;
    logic tick31;
    logic tick15;
    logic hDiv_reg;
    logic [9:0] field_reg;
    logic [9:0] field_next;
    logic [1:0] mod3_reg;
    logic [2:0] mod5a_reg;
    logic [2:0] mod5b_reg;
    logic [2:0] mod7_reg;
    logic spareHalf_reg;
    logic w3;
    logic w5a;
    logic w5b;
    logic w7;
    logic [8:0] alt_reg;
    logic [8:0] alt_next;
    logic [3:0] upper;
    logic upperClockGate;
    logic cycleEnd;
    logic selPrev_reg;
    logic selRise;
    logic selFall;
    logic [DELAY_W-1:0] delayClamp;
    tvs_pulse_state_type delayState_reg;
    logic [DELAY_W-1:0] delayCnt_reg;
    logic fieldFall;
    tvs_pulse_state_type widthState_reg;
    logic [WIDTH_W-1:0] widthCnt_reg;
    logic adjustH_reg;
    logic adjustV_reg;

    // Master inputs are synchronous levels; a rising edge is one master period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m31Prev_reg <= 1'b0;
            m15Prev_reg <= 1'b0;
        end else begin
            m31Prev_reg <= master31;
            m15Prev_reg <= master15;
        end
    end
    assign tick31 = master31 & ~m31Prev_reg;
    assign tick15 = master15 & ~m15Prev_reg;

    // Single ten-bit field counter; any count past the last one reloads zero
    always_comb begin
        if (field_reg >= FIELD_LAST) begin
            field_next = FIELD_RESET;
        end else begin
            field_next = field_reg + 10'h001;
        end
    end

    // Fixed interlace: halve for lines, divide by 525 for fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hDiv_reg <= 1'b0;
            field_reg <= FIELD_RESET;
            fixedSync <= '0;
        end else begin
            fixedSync.hSync <= tick31 & hDiv_reg;
            fixedSync.vSync <= tick31 && (field_reg == FIELD_LAST);
            if (tick31) begin
                hDiv_reg <= ~hDiv_reg;
                field_reg <= field_next;
            end
        end
    end

    // Cascade wrap conditions; the first stage advances on the tick, each later stage on the previous wrap
    assign w3 = tick31 && (mod3_reg >= MOD3_LAST);
    assign w5a = w3 && (mod5a_reg >= MOD5_LAST);
    assign w5b = w5a && (mod5b_reg >= MOD5_LAST);
    assign w7 = w5b && (mod7_reg >= MOD7_LAST);

    // Cascaded 3*5*5*7 form; values past the last state also wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod3_reg <= '0;
            mod5a_reg <= '0;
            mod5b_reg <= '0;
            mod7_reg <= '0;
            spareHalf_reg <= 1'b0;
            cascadeSync <= '0;
        end else begin
            if (tick31) begin
                mod3_reg <= w3 ? 2'h0 : mod3_reg + 2'h1;
                spareHalf_reg <= ~spareHalf_reg;
            end
            if (w3) begin
                mod5a_reg <= w5a ? 3'h0 : mod5a_reg + 3'h1;
            end
            if (w5a) begin
                mod5b_reg <= w5b ? 3'h0 : mod5b_reg + 3'h1;
            end
            if (w5b) begin
                mod7_reg <= w7 ? 3'h0 : mod7_reg + 3'h1;
            end
            cascadeSync.hSync <= tick31 & spareHalf_reg;
            cascadeSync.vSync <= w7;
        end
    end

    // Upper four stages and the gate that feeds them while the top is set
    assign upper = alt_reg[TOP_BIT:LOW_BITS];
    assign upperClockGate = tick15 & alt_reg[TOP_BIT];
    assign cycleEnd = upperClockGate && (upper == UPPER_LAST);

    // Alternating divider; low five are cleared while the top stage is set
    always_comb begin
        alt_next = alt_reg;
        if (!alt_reg[TOP_BIT]) begin
            alt_next = alt_reg + 9'h001;
        end else if (upper == UPPER_JUMP0 - 4'h2) begin
            // Only at count 256 do the upper bits read 1000
            alt_next = {(interlaceSel ? UPPER_JUMP1 : UPPER_JUMP0), 5'h00};
        end else begin
            alt_next = {upper + 4'h1, 5'h00};
        end
    end

    // Divider cycle is 263 with select low, 262 with select high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_reg <= ALT_RESET;
        end else if (tick15) begin
            alt_reg <= alt_next;
        end
    end

    // Select flop flips at each overflow so cycle lengths alternate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interlaceSel <= 1'b0;
        end else if (cycleEnd) begin
            interlaceSel <= ~interlaceSel;
        end
    end

    // Line pulse on every 15.75 kHz period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adjustH_reg <= 1'b0;
        end else begin
            adjustH_reg <= tick15;
        end
    end

    // Select edges seen one cycle after the flop changes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selPrev_reg <= 1'b0;
        end else begin
            selPrev_reg <= interlaceSel;
        end
    end
    assign selRise = interlaceSel & ~selPrev_reg;
    assign selFall = ~interlaceSel & selPrev_reg;
    // Delay over the documented range is clipped rather than wrapped
    assign delayClamp = (interlaceDelay > DELAY_W'(DELAY_MAX)) ?
                        DELAY_W'(DELAY_MAX) : interlaceDelay;

    // Field pulse: undelayed field falls at select fall, other after delay
    always_comb begin
        fieldFall = 1'b0;
        if (selFall) begin
            fieldFall = 1'b1;
        end else if (selRise && !alt_reg[TOP_BIT] && delayClamp == '0) begin
            fieldFall = 1'b1;
        end else if (delayState_reg == PULSE_BUSY && delayCnt_reg == 13'h0001) begin
            fieldFall = 1'b1;
        end
    end

    // Delay stage timed in clk cycles so it is immune to supply drift
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            delayState_reg <= PULSE_IDLE;
            delayCnt_reg <= '0;
            fieldPulse <= 1'b0;
        end else begin
            case (delayState_reg)
                PULSE_IDLE: begin
                    if (selRise && !alt_reg[TOP_BIT] && delayClamp != '0) begin
                        delayState_reg <= PULSE_BUSY;
                        delayCnt_reg <= delayClamp;
                        fieldPulse <= 1'b1;
                    end
                end
                PULSE_BUSY: begin
                    if (selFall || delayCnt_reg == 13'h0001) begin
                        delayState_reg <= PULSE_IDLE;
                        fieldPulse <= 1'b0;
                    end else begin
                        delayCnt_reg <= delayCnt_reg - 13'h0001;
                    end
                end
                default: begin
                    delayState_reg <= PULSE_IDLE;
                    fieldPulse <= 1'b0;
                end
            endcase
        end
    end

    // Vertical sync width stage; a zero width still gives one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            widthState_reg <= PULSE_IDLE;
            widthCnt_reg <= '0;
            adjustV_reg <= 1'b0;
        end else begin
            case (widthState_reg)
                PULSE_IDLE: begin
                    if (fieldFall) begin
                        widthState_reg <= PULSE_BUSY;
                        adjustV_reg <= 1'b1;
                        widthCnt_reg <= (verticalPulseWidth < WIDTH_MIN) ?
                                        WIDTH_MIN : verticalPulseWidth;
                    end
                end
                PULSE_BUSY: begin
                    if (widthCnt_reg <= WIDTH_MIN) begin
                        widthState_reg <= PULSE_IDLE;
                        adjustV_reg <= 1'b0;
                    end else begin
                        widthCnt_reg <= widthCnt_reg - WIDTH_MIN;
                    end
                end
                default: begin
                    widthState_reg <= PULSE_IDLE;
                    adjustV_reg <= 1'b0;
                end
            endcase
        end
    end

    // Each half has one process driving it, so the struct has a single driver
    assign adjustSync = '{hSync: adjustH_reg, vSync: adjustV_reg};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_atSkip;
        tick15 && alt_reg == SKIP_POINT;
    endsequence
    sequence s_overflow;
        cycleEnd ##1 (alt_reg == ALT_RESET);
    endsequence

    property p_line_half;
        fixedSync.hSync |-> !$past(fixedSync.hSync) && !hDiv_reg;
    endproperty
    a_line_half: assert property (p_line_half) else $error("line pulse off");

    property p_field_range;
        field_reg <= FIELD_LAST;
    endproperty
    a_field_range: assert property (p_field_range) else $error("field count");

    property p_field_wrap;
        tick31 && field_reg == FIELD_LAST |=> field_reg == '0 && fixedSync.vSync;
    endproperty
    a_field_wrap: assert property (p_field_wrap) else $error("no wrap");

    property p_field_hold;
        !tick31 |=> $stable(field_reg) && !fixedSync.vSync;
    endproperty
    a_field_hold: assert property (p_field_hold) else $error("field moved");

    property p_cascade_same;
        cascadeSync == fixedSync;
    endproperty
    a_cascade_same: assert property (p_cascade_same) else $error("cascade differs");

    property p_jump;
        s_atSkip |=> alt_reg == (interlaceSel ? JUMP_COUNT1 : JUMP_COUNT0);
    endproperty
    a_jump: assert property (p_jump) else $error("bad jump");

    property p_low_held;
        alt_reg[TOP_BIT] |-> alt_reg[LOW_BITS-1:0] == '0;
    endproperty
    a_low_held: assert property (p_low_held) else $error("low stages moved");

    property p_overflow;
        s_overflow |-> interlaceSel != $past(interlaceSel);
    endproperty
    a_overflow: assert property (p_overflow) else $error("no toggle");

    property p_line15;
        tick15 |=> adjustSync.hSync;
    endproperty
    a_line15: assert property (p_line15) else $error("no line pulse");

    property p_field_low;
        selFall |=> !fieldPulse ##0 adjustSync.vSync;
    endproperty
    a_field_low: assert property (p_field_low) else $error("field not low");

    property p_vsync_start;
        fieldFall && widthState_reg == PULSE_IDLE |=> adjustSync.vSync;
    endproperty
    a_vsync_start: assert property (p_vsync_start) else $error("no vsync");
endmodule : tvs_sync_divider

/* File: verif/tvs_sweep_model.sv */
// Sweep-side model that counts the line and field pulses it receives
`timescale 1ns/1ns
module tvs_sweep_model (
    input wire logic clk,
    input wire logic rst,
    input wire tvs_pkg::tvs_sync_type syncIn,
    output int lineCount,
    output int fieldCount
);
    import tvs_pkg::*;

    // The sweep only listens; it never drives the divider, so nothing can stall it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineCount <= 0;
            fieldCount <= 0;
        end else begin
            lineCount <= lineCount + int'(syncIn.hSync);
            fieldCount <= fieldCount + int'(syncIn.vSync);
        end
    end
endmodule : tvs_sweep_model

/* File: verif/tvs_sync_divider_bench.sv */
// Self-checking bench for the interlaced sync divider
`timescale 1ns/1ns
module tvs_sync_divider_bench;
    import tvs_pkg::*;
    localparam int unsigned DMAX = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic master31 = 1'b0;
    logic master15 = 1'b0;
    logic [DELAY_W-1:0] interlaceDelay = 13'h0000;
    logic [WIDTH_W-1:0] verticalPulseWidth = 16'h0001;
    tvs_sync_type fixedSync;
    tvs_sync_type cascadeSync;
    tvs_sync_type adjustSync;
    logic fieldPulse;
    logic interlaceSel;
    int lineCount;
    int fieldCount;
    int mismatches = 0;
    int n_checks = 0;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    tvs_sync_divider #(.DELAY_MAX(DMAX)) i_dut (
        .clk(clk),
        .rst(rst),
        .master31(master31),
        .master15(master15),
        .interlaceDelay(interlaceDelay),
        .verticalPulseWidth(verticalPulseWidth),
        .fixedSync(fixedSync),
        .cascadeSync(cascadeSync),
        .adjustSync(adjustSync),
        .fieldPulse(fieldPulse),
        .interlaceSel(interlaceSel)
    );

    tvs_sweep_model i_sweep (
        .clk(clk),
        .rst(rst),
        .syncIn(fixedSync),
        .lineCount(lineCount),
        .fieldCount(fieldCount)
    );

    // Verdict and end of run
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // Compare one design bit with case equality so an unknown never matches
    task automatic chkBit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chkBit

    // Compare a count gathered by the bench or the sweep model
    task automatic chkCnt(input int got, input int exp, input string what);
        n_checks++;
        if (got != exp) begin
            mismatches++;
            $display("FAIL %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chkCnt

    // Inputs always move 1 ns after the rising edge
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // Fixed interlace: 1050 master periods cover two whole fields
    task automatic runFixed();
        for (int n = 1; n <= 1050; n++) begin
            // Registered pulses stand only in the cycle right after the tick edge
            master31 = 1'b1;
            step();
            chkBit(fixedSync.hSync, (n % 2) == 0, "line pulse");
            chkBit(fixedSync.vSync, (n % 525) == 0, "field pulse");
            chkBit(cascadeSync.hSync, (n % 2) == 0, "cascade line");
            chkBit(cascadeSync.vSync, (n % 525) == 0, "cascade field");
            master31 = 1'b0;
            step();
            chkBit(fixedSync.vSync, 1'b0, "field pulse width");
            chkBit(fixedSync.hSync, 1'b0, "line pulse width");
        end
        chkCnt(lineCount, 525, "sweep lines");
        chkCnt(fieldCount, 2, "sweep fields");
    endtask : runFixed

    // Time the delayed field pulse and then the vertical sync width
    task automatic measureField(input int expDelay, input int expWidth);
        int n1;
        int n2;
        n1 = 0;
        n2 = 0;
        step();
        while (fieldPulse === 1'b1 && n1 < 100) begin
            n1++;
            step();
        end
        chkCnt(n1, expDelay, "field delay");
        while (adjustSync.vSync === 1'b1 && n2 < 100) begin
            n2++;
            step();
        end
        chkCnt(n2, expWidth, "vsync width");
        if (n1 == 100 || n2 == 100) begin
            summarize();
        end
    endtask : measureField

    // Alternating divider: count ticks per select period, time each field sync
    task automatic runAlt(input int fields, input int dRise, input int width);
        int ticks;
        int done;
        logic sel;
        ticks = 0;
        done = 0;
        sel = interlaceSel;
        while (done < fields) begin
            // Line pulse and select change both show just after the tick edge
            master15 = 1'b1;
            step();
            ticks++;
            chkBit(adjustSync.hSync, 1'b1, "line tick");
            master15 = 1'b0;
            if (interlaceSel !== sel) begin
                chkCnt(ticks, sel ? 262 : 263, "divider cycle");
                sel = interlaceSel;
                ticks = 0;
                done++;
                measureField(sel ? dRise : 0, width);
            end else begin
                step();
                chkBit(adjustSync.hSync, 1'b0, "line tick width");
            end
            if (ticks > 300) begin
                mismatches++;
                $display("FAIL %0t select never toggled", $time);
                summarize();
            end
        end
    endtask : runAlt

    // Main sequence: reset, fixed variant, then three interlace settings
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        step();
        chkBit(interlaceSel, 1'b0, "select after reset");
        runFixed();
        interlaceDelay = 13'h0007;
        verticalPulseWidth = 16'h0003;
        runAlt(2, 7, 3);
        // Delay beyond the limit is clipped, zero width acts as one cycle
        interlaceDelay = 13'h001e;
        verticalPulseWidth = 16'h0000;
        runAlt(2, DMAX, 1);
        interlaceDelay = 13'h0000;
        verticalPulseWidth = 16'h0005;
        runAlt(2, 0, 5);
        summarize();
    end
endmodule : tvs_sync_divider_bench
